//--- pkg/lqm_pkg.sv
// package: register indexes, field positions, reset values and carrier types
package lqm_pkg;

    // ==========================================================
    // register indexes, byte address is four times the index
    localparam logic [11:0] IDX_TRAIN  = 12'h543;
    localparam logic [11:0] IDX_RXTIME = 12'h544;
    localparam logic [11:0] IDX_LATCH  = 12'h545;
    localparam logic [11:0] IDX_COUNTS = 12'h547;
    localparam logic [11:0] IDX_COMM   = 12'h548;
    localparam logic [11:0] IDX_UNCORR = 12'h552;
    localparam logic [11:0] IDX_WDOG   = 12'h559;
    localparam logic [11:0] IDX_SYMPOL = 12'h55B;
    localparam logic [11:0] IDX_NONE   = 12'h000;

    // ==========================================================
    // reset values
    localparam logic [15:0] WDOG_RST   = 16'h0051;
    localparam logic [15:0] SYMPOL_RST = 16'h0000;
    localparam logic [15:0] LATCH_RST  = 16'h0000;
    localparam logic [15:0] COUNT_RST  = 16'h0000;

    // ==========================================================
    // field positions
    localparam int LAT_CHAN   = 5;
    localparam int LAT_INHIB  = 4;
    localparam int LAT_SIGDET = 3;
    localparam int LAT_FERR   = 2;
    localparam int LAT_BLK    = 1;
    localparam int LAT_WDOG   = 0;
    localparam int WDOG_FVAL  = 6;
    localparam int WDOG_FEN   = 5;
    localparam int WDOG_IEEE  = 4;
    localparam int WDOG_TH_HI = 3;
    localparam int SYM_FOLLOW = 4;
    localparam int SYM_RXORD  = 3;
    localparam int SYM_RXPOL  = 2;
    localparam int SYM_TXORD  = 1;
    localparam int SYM_TXPOL  = 0;
    localparam int LOSS_LSB   = 10;

    // ==========================================================
    // timing and symbol coding
    localparam logic [15:0] WDOG_WIN_CYC = 16'h0100;
    localparam logic [1:0]  SYM_ZERO     = 2'h0;
    localparam logic [1:0]  SYM_POS      = 2'h1;
    localparam logic [1:0]  SYM_NEG      = 2'h3;
    localparam int          SYM_N        = 7;

    // ==========================================================
    // carrier types
    typedef logic [SYM_N-1:0][1:0] lqm_symbols_type;

    typedef struct packed {
        logic [7:0] train_ms;
        logic [7:0] remote_ms;
        logic [7:0] local_ms;
        logic       comm_ready;
    } lqm_stat_type;

    typedef struct packed {
        logic link_loss;
        logic link_fail;
        logic uncorr_frame;
        logic chan_good;
        logic fail_inhibit;
        logic sigdet;
        logic send_s;
        logic high_ferr;
        logic blk_lock;
        logic link_up;
        logic is_slave;
        logic rx_pol_detected;
    } lqm_event_type;

    typedef struct packed {
        lqm_symbols_type sym;
    } lqm_map_state_type;

    typedef struct packed {
        logic [31:0] hrdata;
        logic        hreadyout;
        logic        hresp;
        logic        wr_pend;
        logic        rd_pend;
        logic [11:0] idx;
        logic [6:0]  wdog_cfg;
        logic [4:0]  sympol;
        logic [5:0]  latch;
        logic [5:0]  loss_cnt;
        logic [9:0]  fail_cnt;
        logic [15:0] uncorr;
        logic [15:0] win_cnt;
        logic [3:0]  cnt_zero;
        logic [3:0]  cnt_pos;
        logic [3:0]  cnt_neg;
        logic        wdog_ok;
        logic        wdog_status;
        logic        chan_good_q;
    } lqm_state_type;

    localparam lqm_state_type STATE_RST = '{
        default:     '0,
        hreadyout:   1'b1,
        wdog_cfg:    WDOG_RST[6:0],
        sympol:      SYMPOL_RST[4:0],
        latch:       LATCH_RST[5:0],
        loss_cnt:    COUNT_RST[5:0],
        fail_cnt:    COUNT_RST[9:0],
        uncorr:      COUNT_RST,
        wdog_ok:     1'b1,
        wdog_status: 1'b1
    };

endpackage : lqm_pkg

//--- hdl/lqm_symbol_map.sv
// symbol order reversal and polarity inversion for one direction
`timescale 1ns/1ps
`default_nettype none

module lqm_symbol_map (
    input  wire logic                      clock,
    input  wire logic                      rst,
    input  wire logic                      order_inv,
    input  wire logic                      pol_inv,
    input  wire lqm_pkg::lqm_symbols_type  sym_in,
    output var  lqm_pkg::lqm_symbols_type  sym_out
);

    lqm_pkg::lqm_map_state_type st;
    lqm_pkg::lqm_map_state_type next_st;

    // ==========================================================
    // pam3 negate, the unused code maps to zero
    function automatic logic [1:0] negate(input logic [1:0] s);
        if (s == lqm_pkg::SYM_POS) begin
            return lqm_pkg::SYM_NEG;
        end else if (s == lqm_pkg::SYM_NEG) begin
            return lqm_pkg::SYM_POS;
        end
        return lqm_pkg::SYM_ZERO;
    endfunction : negate

    always_comb begin
        next_st = st;
        for (int i = 0; i < lqm_pkg::SYM_N; i++) begin
            if (order_inv) begin
                next_st.sym[i] = sym_in[lqm_pkg::SYM_N-1-i];
            end else begin
                next_st.sym[i] = sym_in[i];
            end
            if (pol_inv) begin
                next_st.sym[i] = negate(next_st.sym[i]);
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sym_out = st.sym;

endmodule : lqm_symbol_map

`default_nettype wire

//--- hdl/lqm_regs.sv
// link quality monitor register bank with watchdog and symbol mapping
// Function
// - training time in ms, low byte
// - remote and local receiver times in ms
// - six-bit link loss counter, upper bits
// - ten-bit link fail without loss counter
// - communication ready bit at position zero
// - uncorrectable frame counter, saturating, cleared on read
// - channel good latched low, write zero clears
// - fail inhibit latched high, write zero clears
// - training signal detect latched high
// - high frame error latched high
// - block lock latched low, write zero sets
// - watchdog latched low, write zero sets
// - force enable drives watchdog from force value
// - watchdog counters start after link up
// - symbol counts reaching threshold keep watchdog quiet
// - slave transmit polarity may follow received polarity
// - reverse received symbol order when set
// - invert received symbol polarity when set
// - reverse transmit symbol order when set
// - invert transmit symbol polarity when set
//
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module lqm_regs (
    input  wire logic                      clock,
    input  wire logic                      rst,
    input  wire logic                      hsel,
    input  wire logic [31:0]               haddr,
    input  wire logic [1:0]                htrans,
    input  wire logic                      hwrite,
    input  wire logic [2:0]                hsize,
    input  wire logic [31:0]               hwdata,
    input  wire logic                      hready,
    output logic      [31:0]               hrdata,
    output logic                           hreadyout,
    output logic                           hresp,
    input  wire lqm_pkg::lqm_stat_type     stat,
    input  wire lqm_pkg::lqm_event_type    evt,
    input  wire lqm_pkg::lqm_symbols_type  tx_sym_in,
    input  wire lqm_pkg::lqm_symbols_type  rx_sym_in,
    output var  lqm_pkg::lqm_symbols_type  tx_sym_out,
    output var  lqm_pkg::lqm_symbols_type  rx_sym_out,
    output logic                           wdog_status
);

    lqm_pkg::lqm_state_type st;
    lqm_pkg::lqm_state_type next_st;

    logic [15:0] rd_val;
    logic        accept;
    logic        rd_clr;
    logic        wr_latch;
    logic        run;
    logic        win_end;
    logic [3:0]  th;
    logic        tx_pol_eff;

    // ==========================================================
    // helpers
    function automatic logic addr_ok(input logic [31:0] a);
        return (a[31:14] == 18'h00000) && (a[1:0] == 2'b00);
    endfunction : addr_ok

    function automatic logic has_kind(input lqm_pkg::lqm_symbols_type s,
                                      input logic [1:0] code);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < lqm_pkg::SYM_N; i++) begin
            hit = hit | (s[i] == code);
        end
        return hit;
    endfunction : has_kind

    function automatic logic [3:0] inc4(input logic [3:0] c, input logic hit);
        if (hit && c != 4'hF) begin
            return c + 4'h1;
        end
        return c;
    endfunction : inc4

    // ==========================================================
    // next state
    always_comb begin
        next_st  = st;
        rd_val   = 16'h0000;
        accept   = hsel && htrans[1] && hready;
        rd_clr   = st.rd_pend && (st.idx == lqm_pkg::IDX_UNCORR);
        wr_latch = st.wr_pend && (st.idx == lqm_pkg::IDX_LATCH);
        th       = st.wdog_cfg[lqm_pkg::WDOG_TH_HI:0];
        run      = !st.wdog_cfg[lqm_pkg::WDOG_IEEE] || evt.link_up;
        win_end  = (st.win_cnt == lqm_pkg::WDOG_WIN_CYC - 16'h0001);

        // read decode, unmapped and reserved bits read as zero
        if (st.idx == lqm_pkg::IDX_TRAIN) begin
            rd_val = {8'h00, stat.train_ms};
        end else if (st.idx == lqm_pkg::IDX_RXTIME) begin
            rd_val = {stat.remote_ms, stat.local_ms};
        end else if (st.idx == lqm_pkg::IDX_LATCH) begin
            rd_val = {10'h000, st.latch};
        end else if (st.idx == lqm_pkg::IDX_COUNTS) begin
            rd_val = {st.loss_cnt, st.fail_cnt};
        end else if (st.idx == lqm_pkg::IDX_COMM) begin
            rd_val = {15'h0000, stat.comm_ready};
        end else if (st.idx == lqm_pkg::IDX_UNCORR) begin
            rd_val = st.uncorr;
        end else if (st.idx == lqm_pkg::IDX_WDOG) begin
            rd_val = {9'h000, st.wdog_cfg};
        end else if (st.idx == lqm_pkg::IDX_SYMPOL) begin
            rd_val = {11'h000, st.sympol};
        end

        // bus: writes zero wait, reads one wait state
        next_st.hreadyout = 1'b1;
        next_st.hresp     = 1'b0;
        next_st.wr_pend   = 1'b0;
        next_st.rd_pend   = 1'b0;
        if (st.rd_pend) begin
            next_st.hrdata = {16'h0000, rd_val};
        end
        if (accept) begin
            next_st.idx       = addr_ok(haddr) ? haddr[13:2] : lqm_pkg::IDX_NONE;
            next_st.wr_pend   = hwrite;
            next_st.rd_pend   = !hwrite;
            next_st.hreadyout = hwrite;
        end

        // writable fields only; statistics are never written
        if (st.wr_pend && st.idx == lqm_pkg::IDX_WDOG) begin
            next_st.wdog_cfg = hwdata[6:0];
        end
        if (st.wr_pend && st.idx == lqm_pkg::IDX_SYMPOL) begin
            next_st.sympol = hwdata[4:0];
        end

        // counters, saturating; link counters live until reset, frame counter cleared on read
        if (evt.link_loss && st.loss_cnt != 6'h3F) begin
            next_st.loss_cnt = st.loss_cnt + 6'h01;
        end
        if (evt.link_fail && st.fail_cnt != 10'h3FF) begin
            next_st.fail_cnt = st.fail_cnt + 10'h001;
        end
        // a frame seen during the clearing read counts as one
        next_st.uncorr = rd_clr ? 16'h0000 : st.uncorr;
        if (evt.uncorr_frame && next_st.uncorr != 16'hFFFF) begin
            next_st.uncorr = next_st.uncorr + 16'h0001;
        end

        // latched flags: hardware events win over software writes
        next_st.chan_good_q = evt.chan_good;
        if (wr_latch && !hwdata[lqm_pkg::LAT_CHAN]) begin
            next_st.latch[lqm_pkg::LAT_CHAN] = 1'b0;
        end
        if (evt.chan_good && !st.chan_good_q) begin
            next_st.latch[lqm_pkg::LAT_CHAN] = 1'b1;
        end
        if (!evt.chan_good) begin
            next_st.latch[lqm_pkg::LAT_CHAN] = 1'b0;
        end
        if (wr_latch && !hwdata[lqm_pkg::LAT_INHIB]) begin
            next_st.latch[lqm_pkg::LAT_INHIB] = 1'b0;
        end
        if (evt.fail_inhibit) begin
            next_st.latch[lqm_pkg::LAT_INHIB] = 1'b1;
        end
        if (wr_latch && !hwdata[lqm_pkg::LAT_SIGDET]) begin
            next_st.latch[lqm_pkg::LAT_SIGDET] = 1'b0;
        end
        if (evt.sigdet && evt.send_s) begin
            next_st.latch[lqm_pkg::LAT_SIGDET] = 1'b1;
        end
        if (wr_latch && !hwdata[lqm_pkg::LAT_FERR]) begin
            next_st.latch[lqm_pkg::LAT_FERR] = 1'b0;
        end
        if (evt.high_ferr) begin
            next_st.latch[lqm_pkg::LAT_FERR] = 1'b1;
        end
        if (wr_latch && !hwdata[lqm_pkg::LAT_BLK]) begin
            next_st.latch[lqm_pkg::LAT_BLK] = 1'b1;
        end
        if (!evt.blk_lock) begin
            next_st.latch[lqm_pkg::LAT_BLK] = 1'b0;
        end
        if (wr_latch && !hwdata[lqm_pkg::LAT_WDOG]) begin
            next_st.latch[lqm_pkg::LAT_WDOG] = 1'b1;
        end
        if (!st.wdog_status) begin
            next_st.latch[lqm_pkg::LAT_WDOG] = 1'b0;
        end

        // watchdog windows over received symbols
        if (!run) begin
            next_st.win_cnt  = 16'h0000;
            next_st.cnt_zero = 4'h0;
            next_st.cnt_pos  = 4'h0;
            next_st.cnt_neg  = 4'h0;
            next_st.wdog_ok  = 1'b1;
        end else begin
            next_st.cnt_zero = inc4(st.cnt_zero, has_kind(rx_sym_in, lqm_pkg::SYM_ZERO));
            next_st.cnt_pos  = inc4(st.cnt_pos, has_kind(rx_sym_in, lqm_pkg::SYM_POS));
            next_st.cnt_neg  = inc4(st.cnt_neg, has_kind(rx_sym_in, lqm_pkg::SYM_NEG));
            next_st.win_cnt  = st.win_cnt + 16'h0001;
            if (win_end) begin
                next_st.wdog_ok = (next_st.cnt_zero >= th) &&
                                  (next_st.cnt_pos >= th) &&
                                  (next_st.cnt_neg >= th);
                next_st.win_cnt  = 16'h0000;
                next_st.cnt_zero = 4'h0;
                next_st.cnt_pos  = 4'h0;
                next_st.cnt_neg  = 4'h0;
            end
        end
        if (st.wdog_cfg[lqm_pkg::WDOG_FEN]) begin
            next_st.wdog_status = st.wdog_cfg[lqm_pkg::WDOG_FVAL];
        end else begin
            next_st.wdog_status = st.wdog_ok;
        end

        // slave may take its transmit polarity from the receiver
        if (st.sympol[lqm_pkg::SYM_FOLLOW] && evt.is_slave) begin
            tx_pol_eff = evt.rx_pol_detected;
        end else begin
            tx_pol_eff = st.sympol[lqm_pkg::SYM_TXPOL];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            st <= lqm_pkg::STATE_RST;
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // symbol mapping; order reversal only makes sense between like devices
    lqm_symbol_map u_tx_map (
        .clock     (clock),
        .rst       (rst),
        .order_inv (st.sympol[lqm_pkg::SYM_TXORD]),
        .pol_inv   (tx_pol_eff),
        .sym_in    (tx_sym_in),
        .sym_out   (tx_sym_out)
    );

    lqm_symbol_map u_rx_map (
        .clock     (clock),
        .rst       (rst),
        .order_inv (st.sympol[lqm_pkg::SYM_RXORD]),
        .pol_inv   (st.sympol[lqm_pkg::SYM_RXPOL]),
        .sym_in    (rx_sym_in),
        .sym_out   (rx_sym_out)
    );

    assign hrdata      = st.hrdata;
    assign hreadyout   = st.hreadyout;
    assign hresp       = st.hresp;
    assign wdog_status = st.wdog_status;

    // ==========================================================
    // checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    sequence rd_accept;
        hsel && htrans[1] && hready && !hwrite;
    endsequence

    sequence rd_of(logic [11:0] i);
        st.rd_pend && st.idx == i;
    endsequence

    read_wait_a: assert property (rd_accept |=> !hreadyout ##1 hreadyout)
        else $error("read did not answer after one wait state");
    train_read_a: assert property (rd_of(lqm_pkg::IDX_TRAIN)
        |=> hrdata == {24'h000000, $past(stat.train_ms)})
        else $error("training time read wrong");
    rxtime_read_a: assert property (rd_of(lqm_pkg::IDX_RXTIME)
        |=> hrdata[15:0] == {$past(stat.remote_ms), $past(stat.local_ms)})
        else $error("receiver time read wrong");
    loss_count_a: assert property (evt.link_loss && st.loss_cnt != 6'h3F
        |=> st.loss_cnt == $past(st.loss_cnt) + 6'h01)
        else $error("link loss not counted");
    fail_count_a: assert property (evt.link_fail && st.fail_cnt != 10'h3FF
        |=> st.fail_cnt == $past(st.fail_cnt) + 10'h001)
        else $error("link fail not counted");
    comm_read_a: assert property (rd_of(lqm_pkg::IDX_COMM)
        |=> hrdata == {31'h00000000, $past(stat.comm_ready)})
        else $error("comm ready read wrong");
    uncorr_sat_a: assert property (st.uncorr == 16'hFFFF && !rd_clr
        |=> st.uncorr == 16'hFFFF)
        else $error("frame counter left saturation");
    uncorr_clear_a: assert property (rd_clr && !evt.uncorr_frame
        |=> st.uncorr == 16'h0000 && hrdata[15:0] == $past(st.uncorr))
        else $error("frame counter not cleared on read");
    chan_drop_a: assert property (!evt.chan_good
        |=> !st.latch[lqm_pkg::LAT_CHAN])
        else $error("channel good drop not latched");
    inhibit_set_a: assert property (evt.fail_inhibit
        |=> st.latch[lqm_pkg::LAT_INHIB])
        else $error("fail inhibit not latched");
    sigdet_set_a: assert property (evt.sigdet && evt.send_s
        |=> st.latch[lqm_pkg::LAT_SIGDET])
        else $error("training sigdet not latched");
    ferr_set_a: assert property (evt.high_ferr
        |=> st.latch[lqm_pkg::LAT_FERR])
        else $error("frame error not latched");
    blk_low_a: assert property (!evt.blk_lock
        |=> !st.latch[lqm_pkg::LAT_BLK])
        else $error("block lock loss not latched");
    wdog_low_a: assert property (!st.wdog_status
        |=> !st.latch[lqm_pkg::LAT_WDOG])
        else $error("watchdog low not latched");
    force_wdog_a: assert property (st.wdog_cfg[lqm_pkg::WDOG_FEN]
        |=> wdog_status == $past(st.wdog_cfg[lqm_pkg::WDOG_FVAL]))
        else $error("forced watchdog value not driven");
    idle_ok_a: assert property (!run |=> st.wdog_ok && st.win_cnt == 16'h0000)
        else $error("watchdog ran before link up");
    window_ok_a: assert property (run && win_end &&
        next_st.cnt_zero >= th && next_st.cnt_pos >= th && next_st.cnt_neg >= th
        |=> st.wdog_ok)
        else $error("watchdog flagged despite enough symbols");
    follow_pol_a: assert property (st.sympol[lqm_pkg::SYM_FOLLOW] &&
        evt.is_slave && evt.rx_pol_detected && !st.sympol[lqm_pkg::SYM_TXORD]
        && tx_sym_in[0] == lqm_pkg::SYM_POS |=> tx_sym_out[0] == lqm_pkg::SYM_NEG)
        else $error("slave tx polarity did not follow");
    rx_order_a: assert property (st.sympol[lqm_pkg::SYM_RXORD] &&
        !st.sympol[lqm_pkg::SYM_RXPOL] |=> rx_sym_out[6] == $past(rx_sym_in[0]))
        else $error("rx order not reversed");
    rx_pol_a: assert property (st.sympol[lqm_pkg::SYM_RXPOL] &&
        !st.sympol[lqm_pkg::SYM_RXORD] && rx_sym_in[0] == lqm_pkg::SYM_POS
        |=> rx_sym_out[0] == lqm_pkg::SYM_NEG)
        else $error("rx polarity not inverted");
    tx_order_a: assert property (st.sympol[lqm_pkg::SYM_TXORD] &&
        !tx_pol_eff |=> tx_sym_out[6] == $past(tx_sym_in[0]))
        else $error("tx order not reversed");
    tx_pol_a: assert property (st.sympol[lqm_pkg::SYM_TXPOL] &&
        !st.sympol[lqm_pkg::SYM_FOLLOW] && !st.sympol[lqm_pkg::SYM_TXORD]
        && tx_sym_in[0] == lqm_pkg::SYM_POS |=> tx_sym_out[0] == lqm_pkg::SYM_NEG)
        else $error("tx polarity not inverted");

endmodule : lqm_regs

`default_nettype wire

//--- tb/lqm_link_partner.sv
// link partner model: received symbol stream for the watchdog and mapping checks
`timescale 1ns/1ps
`default_nettype none

module lqm_link_partner (
    input  wire logic                     clock,
    input  wire logic                     quiet,
    output var  lqm_pkg::lqm_symbols_type rx_sym
);
    int         k = 0;
    logic [1:0] lvl [3] = '{2'h0, 2'h1, 2'h3};

    // rotating levels so every cycle carries 0, +1 and -1; quiet starves +1 and -1
    always @(posedge clock) begin
        k <= (k + 1) % 3;
        for (int i = 0; i < 7; i++) begin
            rx_sym[i] <= quiet ? 2'h0 : lvl[(i + k) % 3];
        end
    end
endmodule : lqm_link_partner

`default_nettype wire

//--- tb/lqm_regs_tb_top.sv
// testbench: register bank, latched flags, watchdog and symbol mapping
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin error_cnt++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end

module lqm_regs_tb_top;
    logic                     clock = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic                     quiet = 1'b0, hreadyout, hresp, wdog_status;
    logic [31:0]              haddr = '0, hwdata = '0, hrdata;
    logic [1:0]               htrans = 2'h0;
    lqm_pkg::lqm_stat_type    stat = '0;
    lqm_pkg::lqm_event_type   evt = 12'h008;
    lqm_pkg::lqm_symbols_type tx_in = 14'h1C5D, rx_in, tx_out, rx_out, p;
    int                       error_cnt = 0, compares = 0;

    always #5 clock = ~clock;

    lqm_link_partner lqm_link_partner_i (.clock(clock), .quiet(quiet), .rx_sym(rx_in));
    lqm_regs lqm_regs_i (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .stat(stat), .evt(evt),
        .tx_sym_in(tx_in), .rx_sym_in(rx_in), .tx_sym_out(tx_out), .rx_sym_out(rx_out),
        .wdog_status(wdog_status));

    // ==========================================================
    // bus helpers
    task automatic final_report;
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report

    task automatic wt;
        int n;
        n = 0;
        @(posedge clock);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 50) begin
                error_cnt++;
                final_report();
            end
            @(posedge clock);
        end
    endtask : wt

    // address phase held until hready, then data phase held until hready again
    task automatic bus(input logic wr, input logic [11:0] idx, input logic [15:0] wd,
                       output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {18'h0, idx, 2'h0};
        hwrite <= wr;
        htrans <= 2'h2;
        wt();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {16'h0, wd};
        wt();
        rd = hrdata;
    endtask : bus

    task automatic wr(input logic [11:0] idx, input logic [15:0] wd);
        logic [31:0] r;
        bus(1'b1, idx, wd, r);
    endtask : wr

    task automatic rdc(input logic [11:0] idx, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, idx, 16'h0, r);
        `CHK(r, exp)
        `CHK(hresp, 1'b0)
    endtask : rdc

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask : tick

    function automatic lqm_pkg::lqm_symbols_type map(input lqm_pkg::lqm_symbols_type s,
                                                     input logic ord, input logic pol);
        lqm_pkg::lqm_symbols_type o;
        for (int i = 0; i < 7; i++) begin
            o[i] = s[ord ? 6 - i : i];
            if (pol) o[i] = (o[i] == 2'h1) ? 2'h3 : ((o[i] == 2'h3) ? 2'h1 : 2'h0);
        end
        return o;
    endfunction : map

    // ==========================================================
    // scenarios
    task automatic t_regs;
        stat <= '{8'hA5, 8'h3C, 8'h81, 1'b1};
        rdc(lqm_pkg::IDX_WDOG, 32'h51);
        rdc(lqm_pkg::IDX_LATCH, 32'h0);
        rdc(lqm_pkg::IDX_TRAIN, 32'hA5);
        rdc(lqm_pkg::IDX_RXTIME, 32'h3C81);
        rdc(lqm_pkg::IDX_COMM, 32'h1);
        wr(lqm_pkg::IDX_TRAIN, 16'hFFFF);
        rdc(lqm_pkg::IDX_TRAIN, 32'hA5);
        wr(lqm_pkg::IDX_SYMPOL, 16'hFFFF);
        rdc(lqm_pkg::IDX_SYMPOL, 32'h1F);
        rdc(12'h546, 32'h0);
    endtask : t_regs

    task automatic t_counts;
        for (int i = 0; i < 3; i++) begin
            evt.link_loss <= (i < 2);
            evt.link_fail <= 1'b1;
            evt.uncorr_frame <= 1'b1;
            @(posedge clock);
            evt.link_loss <= 1'b0;
            evt.link_fail <= 1'b0;
            evt.uncorr_frame <= 1'b0;
            @(posedge clock);
        end
        rdc(lqm_pkg::IDX_COUNTS, 32'h0803);
        rdc(lqm_pkg::IDX_UNCORR, 32'h3);
        rdc(lqm_pkg::IDX_UNCORR, 32'h0);
        // long burst of bad frames drives the counter into saturation
        evt.uncorr_frame <= 1'b1;
        tick(65540);
        evt.uncorr_frame <= 1'b0;
        rdc(lqm_pkg::IDX_UNCORR, 32'hFFFF);
        rdc(lqm_pkg::IDX_UNCORR, 32'h0);
    endtask : t_counts

    task automatic t_flags;
        evt.fail_inhibit <= 1'b1;
        evt.sigdet <= 1'b1;
        evt.send_s <= 1'b1;
        evt.high_ferr <= 1'b1;
        evt.chan_good <= 1'b1;
        @(posedge clock);
        evt.fail_inhibit <= 1'b0;
        evt.sigdet <= 1'b0;
        evt.high_ferr <= 1'b0;
        tick(2);
        rdc(lqm_pkg::IDX_LATCH, 32'h3C);
        wr(lqm_pkg::IDX_LATCH, 16'h0);
        rdc(lqm_pkg::IDX_LATCH, 32'h3);
        evt.blk_lock <= 1'b0;
        tick(2);
        wr(lqm_pkg::IDX_LATCH, 16'hFFFF);
        rdc(lqm_pkg::IDX_LATCH, 32'h1);
        evt.blk_lock <= 1'b1;
    endtask : t_flags

    task automatic t_wdog;
        wr(lqm_pkg::IDX_WDOG, 16'h0031);
        tick(3);
        `CHK(wdog_status, 1'b0)
        rdc(lqm_pkg::IDX_LATCH, 32'h0);
        wr(lqm_pkg::IDX_WDOG, 16'h0071);
        tick(3);
        `CHK(wdog_status, 1'b1)
        wr(lqm_pkg::IDX_WDOG, 16'h0051);
        quiet <= 1'b1;
        tick(600);
        `CHK(wdog_status, 1'b1)
        evt.link_up <= 1'b1;
        tick(600);
        `CHK(wdog_status, 1'b0)
        quiet <= 1'b0;
        tick(600);
        `CHK(wdog_status, 1'b1)
        // with the link-up gate off the counters run even without link up
        evt.link_up <= 1'b0;
        quiet <= 1'b1;
        wr(lqm_pkg::IDX_WDOG, 16'h0041);
        tick(600);
        `CHK(wdog_status, 1'b0)
        quiet <= 1'b0;
    endtask : t_wdog

    task automatic t_sym;
        logic [4:0] cfg [9] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h08, 5'h0C, 5'h10, 5'h11};
        evt.is_slave <= 1'b1;
        foreach (cfg[j]) begin
            evt.rx_pol_detected <= j[0];
            wr(lqm_pkg::IDX_SYMPOL, {11'h0, cfg[j]});
            tick(2);
            `CHK(tx_out, map(tx_in, cfg[j][1], cfg[j][4] ? j[0] : cfg[j][0]))
            p = rx_in;
            @(posedge clock);
            `CHK(rx_out, map(p, cfg[j][3], cfg[j][2]))
        end
    endtask : t_sym

    initial begin
        tick(3);
        rst <= 1'b0;
        tick(2);
        t_regs();
        t_counts();
        t_flags();
        t_wdog();
        t_sym();
        final_report();
    end
endmodule : lqm_regs_tb_top

`default_nettype wire
